// >>> icp_pkg.sv
// icp_pkg: constants, keyword tree and carrier types of the command line parser
package icp_pkg;
    // character codes
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_WS_MAX = 8'h20;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_SEMI = 8'h3b;
    localparam logic [7:0] CH_QUERY = 8'h3f;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_UA = 8'h41;
    localparam logic [7:0] CH_UZ = 8'h5a;
    localparam logic [7:0] CH_LA = 8'h61;
    localparam logic [7:0] CH_LZ = 8'h7a;
    localparam logic [7:0] CASE_BIT = 8'h20;
    localparam logic [7:0] CH_ONE = 8'h31;

    // keyword buffer and tree geometry
    localparam int KW_CHARS = 12;
    localparam int KW_BITS = 8 * KW_CHARS;
    localparam int NKW = 16;
    localparam int DEPTH = 4;
    localparam int PBUF_CHARS = 7;
    localparam logic [3:0] KW_MAX_LEN = 4'hc;
    localparam logic [3:0] PLEN_OVER = 4'h8;
    localparam logic [7:0] SFX_DEFAULT = 8'h01;
    localparam logic [7:0] SFX_RADIX = 8'h0a;
    localparam logic [1:0] DEPTH_LAST = 2'h3;

    typedef logic [4:0] icp_node_t;

    typedef struct packed {
        logic [KW_BITS-1:0] name;  // upper case, right aligned
        logic [3:0] len;
        logic [3:0] slen;
        icp_node_t parent;
        logic opt;
    } icp_kw_t;

    // entry 0 is the root; a keyword may appear at several levels
    localparam icp_kw_t KW_TABLE [0:NKW] = '{
        '{"", 4'h0, 4'h0, 5'h00, 1'b0},
        '{"SOURCE", 4'h6, 4'h4, 5'h00, 1'b1},
        '{"FREQUENCY", 4'h9, 4'h4, 5'h01, 1'b0},
        '{"POWER", 4'h5, 4'h3, 5'h01, 1'b0},
        '{"LEVEL", 4'h5, 4'h3, 5'h03, 1'b1},
        '{"IMMEDIATE", 4'h9, 4'h3, 5'h04, 1'b1},
        '{"OFFSET", 4'h6, 4'h4, 5'h05, 1'b0},
        '{"FM", 4'h2, 4'h2, 5'h01, 1'b0},
        '{"AM", 4'h2, 4'h2, 5'h01, 1'b0},
        '{"EXTERNAL", 4'h8, 4'h3, 5'h07, 1'b0},
        '{"INTERNAL", 4'h8, 4'h3, 5'h07, 1'b0},
        '{"COUPLING", 4'h8, 4'h4, 5'h09, 1'b0},
        '{"POLARITY", 4'h8, 4'h3, 5'h07, 1'b0},
        '{"POLARITY", 4'h8, 4'h3, 5'h09, 1'b0},
        '{"OUTPUT", 4'h6, 4'h4, 5'h00, 1'b0},
        '{"STATE", 4'h5, 4'h4, 5'h0e, 1'b0},
        '{"ATTENUATION", 4'hb, 4'h3, 5'h03, 1'b0}
    };

    // special parameter spellings
    localparam logic [23:0] SP_MIN_S = "MIN";
    localparam logic [23:0] SP_MAX_S = "MAX";
    localparam logic [23:0] SP_DEF_S = "DEF";
    localparam logic [55:0] SP_MIN_L = "MINIMUM";
    localparam logic [55:0] SP_MAX_L = "MAXIMUM";
    localparam logic [55:0] SP_DEF_L = "DEFAULT";
    localparam logic [3:0] SP_SLEN = 4'h3;
    localparam logic [3:0] SP_LLEN = 4'h7;

    localparam logic [15:0] POW10 [0:4] = '{16'h2710, 16'h03e8, 16'h0064, 16'h000a, 16'h0001};
    localparam logic [2:0] POW_LAST = 3'h4;

    typedef enum logic [1:0] {SP_NONE, SP_MIN, SP_MAX, SP_DEF} icp_special_t;
    typedef enum logic [1:0] {RK_BOOL, RK_NUM, RK_TEXT} icp_rkind_t;

    typedef struct packed {logic valid; logic [7:0] data; logic eoi;} icp_rx_t;
    typedef struct packed {logic valid; logic [7:0] data; logic [3:0] index;} icp_par_t;
    typedef struct packed {logic valid; logic [7:0] data; logic eoi;} icp_tx_t;
    typedef struct packed {
        logic valid;
        icp_node_t node;
        logic query;
        logic common;
        logic [31:0] cname;
        logic [DEPTH-1:0][7:0] sfx;
        logic [3:0] nparam;
        icp_special_t special;
    } icp_cmd_t;
    typedef struct packed {logic valid; icp_rkind_t kind; logic [15:0] value; icp_node_t node;} icp_rsp_t;
endpackage

// >>> icp_parser.sv
// icp_parser: instrument command line parser and query response formatter
`timescale 1ns/100ps
`default_nettype none

// How it works
// - ascii device message bytes in and out
// - codes 0-9, 11-32 are white space
// - question mark after header marks query
// - leading asterisk means common command
// - colons split keywords into deeper levels
// - keyword meaning depends on its level
// - optional keywords may be present or omitted
// - only full or short spelling accepted
// - keyword compare ignores letter case
// - parameters split at commas
// - detect minimum, maximum, default first parameter, unless eoi is on its last byte
// - missing suffix counts as suffix 1
// - newline, newline+eoi or eoi end lines
// - semicolon splits commands; colon returns root
// - bare semicolon resumes below previous path
// - new line restarts at root, except one after a trailing semicolon
// - every header also accepted as query
// - responses carry value only, no header
// - limit values answered as numbers
// - numbers sent without unit
// - booleans sent as 0 or 1
// - text answers use short spelling
module icp_parser (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire icp_pkg::icp_rx_t i_rx,
    output icp_pkg::icp_cmd_t o_cmd,
    output icp_pkg::icp_par_t o_par,
    output logic o_err,
    input wire icp_pkg::icp_rsp_t i_rsp,
    output logic o_rsp_ready,
    output icp_pkg::icp_tx_t o_tx,
    input wire logic i_tx_ready
);
    typedef enum logic [2:0] {ST_IDLE, ST_KEY, ST_COM, ST_PARAM, ST_SKIP} icp_pstate_t;
    typedef enum logic [2:0] {RS_IDLE, RS_NUM, RS_TXT, RS_LF, RS_WAIT} icp_rstate_t;

    icp_pstate_t st_q, st_d;
    icp_pkg::icp_node_t cur_q, cur_d, base_q, base_d, node_q, node_d;
    logic [icp_pkg::KW_BITS-1:0] kbuf_q, kbuf_d, kbuf_now;
    logic [3:0] klen_q, klen_d, klen_now;
    logic [7:0] sfx_q, sfx_d, sfx_now;
    logic sdig_q, sdig_d, sdig_now;
    logic query_q, query_d, common_q, common_d;
    logic [31:0] cname_q, cname_d;
    logic [1:0] depth_q, depth_d;
    logic [icp_pkg::DEPTH-1:0][7:0] path_q, path_d;
    logic [3:0] pidx_q, pidx_d;
    logic pany_q, pany_d;
    logic [8*icp_pkg::PBUF_CHARS-1:0] pbuf_q, pbuf_d;
    logic [3:0] plen_q, plen_d;
    logic emit, err;
    icp_pkg::icp_cmd_t cmd_q, cmd_d;
    icp_pkg::icp_par_t par_q, par_d;
    logic err_q;

    // byte classification, case folded to upper
    wire [7:0] ch = i_rx.data;
    wire is_lf = (ch == icp_pkg::CH_LF);
    wire is_ws = (ch <= icp_pkg::CH_WS_MAX) && !is_lf;
    wire is_colon = (ch == icp_pkg::CH_COLON);
    wire is_semi = (ch == icp_pkg::CH_SEMI);
    wire is_qm = (ch == icp_pkg::CH_QUERY);
    wire is_star = (ch == icp_pkg::CH_STAR);
    wire is_comma = (ch == icp_pkg::CH_COMMA);
    wire is_digit = (ch >= icp_pkg::CH_ZERO) && (ch <= icp_pkg::CH_NINE);
    wire is_lower = (ch >= icp_pkg::CH_LA) && (ch <= icp_pkg::CH_LZ);
    wire is_alpha = is_lower || ((ch >= icp_pkg::CH_UA) && (ch <= icp_pkg::CH_UZ));
    wire [7:0] ch_up = is_lower ? (ch & ~icp_pkg::CASE_BIT) : ch;
    wire line_end = is_lf || i_rx.eoi;
    wire term_cmd = is_semi || line_end;
    wire kdelim = !(is_alpha || is_digit) || i_rx.eoi;
    wire [3:0] digit = 4'(ch - icp_pkg::CH_ZERO);
    wire in_word = is_alpha && !sdig_q && (klen_q < icp_pkg::KW_MAX_LEN);

    // keyword with the current byte folded in, so an eoi on a letter still counts
    assign kbuf_now = in_word ? {kbuf_q[icp_pkg::KW_BITS-9:0], ch_up} : kbuf_q;
    assign klen_now = in_word ? klen_q + 4'h1 : klen_q;
    assign sfx_now = is_digit ? 8'(sfx_q * icp_pkg::SFX_RADIX + {4'h0, digit}) : sfx_q;
    assign sdig_now = sdig_q || is_digit;

    // keyword lookup: direct child of the current level first, then through up to two optional levels
    logic hit_dir, hit_hop, name_ok, via_1, via_2;
    icp_pkg::icp_node_t dir_node, hop_node, p, pp;
    always_comb begin
        hit_dir = 1'b0;
        hit_hop = 1'b0;
        dir_node = '0;
        hop_node = '0;
        p = '0;
        pp = '0;
        name_ok = 1'b0;
        via_1 = 1'b0;
        via_2 = 1'b0;
        for (int i = icp_pkg::NKW; i >= 1; i--) begin
            p = icp_pkg::KW_TABLE[i].parent;
            pp = icp_pkg::KW_TABLE[p].parent;
            name_ok = (klen_now == icp_pkg::KW_TABLE[i].len && kbuf_now == icp_pkg::KW_TABLE[i].name) ||
                (klen_now == icp_pkg::KW_TABLE[i].slen &&
                kbuf_now == (icp_pkg::KW_TABLE[i].name >>
                {icp_pkg::KW_TABLE[i].len - icp_pkg::KW_TABLE[i].slen, 3'b000}));
            via_1 = icp_pkg::KW_TABLE[p].opt && pp == cur_q;
            via_2 = icp_pkg::KW_TABLE[p].opt && icp_pkg::KW_TABLE[pp].opt &&
                icp_pkg::KW_TABLE[pp].parent == cur_q;
            if (name_ok && p == cur_q) begin
                hit_dir = 1'b1;
                dir_node = icp_pkg::icp_node_t'(i);
            end
            if (name_ok && (via_1 || via_2)) begin
                hit_hop = 1'b1;
                hop_node = icp_pkg::icp_node_t'(i);
            end
        end
    end
    wire hit = hit_dir || hit_hop;
    wire [4:0] hit_node = hit_dir ? dir_node : hop_node;

    // first parameter compared against the special spellings
    wire sp_min = (plen_q == icp_pkg::SP_SLEN && pbuf_q[23:0] == icp_pkg::SP_MIN_S) ||
        (plen_q == icp_pkg::SP_LLEN && pbuf_q == icp_pkg::SP_MIN_L);
    wire sp_max = (plen_q == icp_pkg::SP_SLEN && pbuf_q[23:0] == icp_pkg::SP_MAX_S) ||
        (plen_q == icp_pkg::SP_LLEN && pbuf_q == icp_pkg::SP_MAX_L);
    wire sp_def = (plen_q == icp_pkg::SP_SLEN && pbuf_q[23:0] == icp_pkg::SP_DEF_S) ||
        (plen_q == icp_pkg::SP_LLEN && pbuf_q == icp_pkg::SP_DEF_L);
    wire stream = (st_q == ST_PARAM) && !is_ws && !is_comma && !is_lf && !is_semi;

    // parser next state, one byte per cycle, no back-pressure needed
    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        base_d = base_q;
        node_d = node_q;
        kbuf_d = kbuf_q;
        klen_d = klen_q;
        sfx_d = sfx_q;
        sdig_d = sdig_q;
        query_d = query_q;
        common_d = common_q;
        cname_d = cname_q;
        depth_d = depth_q;
        path_d = path_q;
        pidx_d = pidx_q;
        pany_d = pany_q;
        pbuf_d = pbuf_q;
        plen_d = plen_q;
        emit = 1'b0;
        err = 1'b0;
        par_d = '0;
        if (i_rx.valid) begin
            case (st_q)
                ST_IDLE: begin
                    path_d = {icp_pkg::DEPTH{icp_pkg::SFX_DEFAULT}};
                    cname_d = '0;
                    if (is_colon) begin
                        cur_d = '0;
                        st_d = ST_KEY;
                    end else if (is_star) begin
                        common_d = 1'b1;
                        st_d = ST_COM;
                    end else if (is_alpha) begin
                        kbuf_d = kbuf_now;
                        klen_d = klen_now;
                        st_d = ST_KEY;
                    end else if (!is_ws && !term_cmd) begin
                        err = 1'b1;
                    end
                    if (line_end && !is_ws && !is_lf) begin
                        err = 1'b1;  // line cut short inside a header
                    end
                end
                ST_KEY: begin
                    if (!kdelim) begin
                        kbuf_d = kbuf_now;
                        klen_d = klen_now;
                        sfx_d = sfx_now;
                        sdig_d = sdig_now;
                        if (!in_word && !is_digit) begin
                            err = 1'b1;  // too long or letter after suffix
                        end
                    end else if (!hit) begin
                        err = 1'b1;
                    end else begin
                        path_d[depth_q] = sdig_now ? sfx_now : icp_pkg::SFX_DEFAULT;
                        depth_d = (depth_q == icp_pkg::DEPTH_LAST) ? depth_q : depth_q + 2'h1;
                        node_d = hit_node;
                        kbuf_d = '0;
                        klen_d = '0;
                        sfx_d = '0;
                        sdig_d = 1'b0;
                        query_d = query_q || is_qm;
                        if (is_colon && !line_end) begin
                            cur_d = hit_node;
                        end else if ((is_qm || is_ws) && !line_end) begin
                            st_d = ST_PARAM;
                        end else if (term_cmd && !is_colon) begin
                            emit = 1'b1;
                        end else begin
                            err = 1'b1;
                        end
                    end
                end
                ST_COM: begin
                    if (is_alpha || is_digit || is_qm) begin
                        cname_d = {cname_q[23:0], ch_up};
                        query_d = query_q || is_qm;
                    end
                    if (term_cmd) begin
                        emit = 1'b1;
                    end else if (is_ws) begin
                        st_d = ST_PARAM;
                    end else if (!(is_alpha || is_digit || is_qm)) begin
                        err = 1'b1;
                    end
                end
                ST_PARAM: begin
                    if (is_comma) begin
                        pidx_d = pidx_q + 4'h1;
                    end
                    if (stream) begin
                        par_d = '{valid: 1'b1, data: i_rx.data, index: pidx_q};
                        pany_d = 1'b1;
                        if (pidx_q == '0) begin
                            pbuf_d = {pbuf_q[8*icp_pkg::PBUF_CHARS-9:0], ch_up};
                            plen_d = (plen_q == icp_pkg::PLEN_OVER) ? plen_q : plen_q + 4'h1;
                        end
                    end
                    emit = term_cmd;
                end
                ST_SKIP: begin
                    if (term_cmd) begin
                        st_d = ST_IDLE;
                        cur_d = line_end ? '0 : base_q;
                        base_d = cur_d;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
            // end of command, good or bad: clear per-command state
            if (emit || err) begin
                st_d = (err && !term_cmd) ? ST_SKIP : ST_IDLE;
                kbuf_d = '0;
                klen_d = '0;
                sfx_d = '0;
                sdig_d = 1'b0;
                query_d = 1'b0;
                common_d = 1'b0;
                depth_d = '0;
                pidx_d = '0;
                pany_d = 1'b0;
                pbuf_d = '0;
                plen_d = '0;
                node_d = '0;
                if (line_end) begin
                    cur_d = '0;
                end else if (emit && !common_q) begin
                    cur_d = icp_pkg::KW_TABLE[(st_q == ST_KEY) ? hit_node : node_q].parent;
                end else begin
                    cur_d = base_q;  // errors and common commands leave the path alone
                end
                base_d = cur_d;
            end
        end
    end

    // command record carries node, suffixes, flags, name, parameter count and special, not parameter bytes; settings change downstream, never on error
    assign cmd_d = '{valid: emit, node: (st_q == ST_KEY) ? hit_node : node_q,
        query: query_q | (is_qm && st_q != ST_PARAM), common: common_q, cname: cname_d,
        sfx: (st_q == ST_KEY) ? path_d : path_q,
        nparam: (stream || pany_q) ? pidx_q + 4'h1 : 4'h0,
        special: sp_min ? icp_pkg::SP_MIN : sp_max ? icp_pkg::SP_MAX : sp_def ? icp_pkg::SP_DEF : icp_pkg::SP_NONE};

    // parser registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q <= ST_IDLE;
            {cur_q, base_q, node_q, kbuf_q, klen_q, sfx_q, sdig_q} <= '0;
            {query_q, common_q, cname_q, depth_q, pidx_q, pany_q, pbuf_q, plen_q} <= '0;
            path_q <= {icp_pkg::DEPTH{icp_pkg::SFX_DEFAULT}};
            {cmd_q, par_q, err_q} <= '0;
        end else begin
            st_q <= st_d;
            {cur_q, base_q, node_q, kbuf_q, klen_q, sfx_q, sdig_q} <= {cur_d, base_d, node_d, kbuf_d, klen_d, sfx_d, sdig_d};
            {query_q, common_q, cname_q, depth_q} <= {query_d, common_d, cname_d, depth_d};
            {pidx_q, pany_q, pbuf_q, plen_q, path_q} <= {pidx_d, pany_d, pbuf_d, plen_d, path_d};
            cmd_q <= emit ? cmd_d : '0;
            par_q <= par_d;
            err_q <= err;
        end
    end
    assign o_cmd = cmd_q;
    assign o_par = par_q;
    assign o_err = err_q;

    // response formatter: value only, never the header, then newline with eoi
    icp_rstate_t rs_q, rs_d, after_q, after_d;
    icp_pkg::icp_tx_t tx_q, tx_d;
    logic [15:0] rem_q, rem_d;
    logic [2:0] pw_q, pw_d;
    logic [3:0] dig_q, dig_d, tidx_q, tidx_d;
    logic started_q, started_d;
    icp_pkg::icp_node_t tnode_q, tnode_d;
    wire [15:0] pow = icp_pkg::POW10[pw_q];
    wire [icp_pkg::KW_BITS-1:0] txt_word = icp_pkg::KW_TABLE[tnode_q].name >>
        {icp_pkg::KW_TABLE[tnode_q].len - tidx_q - 4'h1, 3'b000};
    assign o_rsp_ready = (rs_q == RS_IDLE);

    always_comb begin
        rs_d = rs_q;
        after_d = after_q;
        tx_d = tx_q;
        rem_d = rem_q;
        pw_d = pw_q;
        dig_d = dig_q;
        tidx_d = tidx_q;
        started_d = started_q;
        tnode_d = tnode_q;
        case (rs_q)
            RS_IDLE: begin
                if (i_rsp.valid) begin
                    rem_d = i_rsp.value;
                    pw_d = '0;
                    dig_d = '0;
                    started_d = 1'b0;
                    tidx_d = '0;
                    tnode_d = i_rsp.node;
                    case (i_rsp.kind)
                        icp_pkg::RK_BOOL: begin
                            tx_d = '{valid: 1'b1, data: i_rsp.value[0] ? icp_pkg::CH_ONE : icp_pkg::CH_ZERO, eoi: 1'b0};
                            rs_d = RS_WAIT;
                            after_d = RS_LF;
                        end
                        icp_pkg::RK_NUM: rs_d = RS_NUM;
                        icp_pkg::RK_TEXT: rs_d = RS_TXT;
                        default: rs_d = RS_LF;
                    endcase
                end
            end
            RS_NUM: begin
                // plain decimal digits, leading zeros dropped, no unit appended
                if (rem_q >= pow) begin
                    rem_d = rem_q - pow;
                    dig_d = dig_q + 4'h1;
                end else begin
                    pw_d = pw_q + 3'h1;
                    if (dig_q != '0 || started_q || pw_q == icp_pkg::POW_LAST) begin
                        tx_d = '{valid: 1'b1, data: icp_pkg::CH_ZERO + {4'h0, dig_q}, eoi: 1'b0};
                        started_d = 1'b1;
                        dig_d = '0;
                        rs_d = RS_WAIT;
                        after_d = (pw_q == icp_pkg::POW_LAST) ? RS_LF : RS_NUM;
                    end
                end
            end
            RS_TXT: begin
                if (tidx_q >= icp_pkg::KW_TABLE[tnode_q].slen) begin
                    rs_d = RS_LF;
                end else begin
                    tx_d = '{valid: 1'b1, data: txt_word[7:0], eoi: 1'b0};
                    tidx_d = tidx_q + 4'h1;
                    rs_d = RS_WAIT;
                    after_d = RS_TXT;
                end
            end
            RS_LF: begin
                tx_d = '{valid: 1'b1, data: icp_pkg::CH_LF, eoi: 1'b1};
                rs_d = RS_WAIT;
                after_d = RS_IDLE;
            end
            RS_WAIT: begin
                if (i_tx_ready) begin
                    tx_d.valid = 1'b0;
                    rs_d = after_q;
                end
            end
            default: rs_d = RS_IDLE;
        endcase
    end

    // formatter registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rs_q <= RS_IDLE;
            after_q <= RS_IDLE;
            {tx_q, rem_q, pw_q, dig_q, tidx_q, started_q, tnode_q} <= '0;
        end else begin
            rs_q <= rs_d;
            after_q <= after_d;
            {tx_q, rem_q, pw_q, dig_q, tidx_q, started_q, tnode_q} <= {tx_d, rem_d, pw_d, dig_d, tidx_d, started_d, tnode_d};
        end
    end
    assign o_tx = tx_q;
endmodule

`default_nettype wire

// >>> icp_parser_asserts.sv
// icp_parser_asserts: port level checks of the command line parser
`timescale 1ns/100ps
`default_nettype none
module icp_parser_asserts (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire icp_pkg::icp_rx_t i_rx,
    input wire icp_pkg::icp_cmd_t o_cmd,
    input wire icp_pkg::icp_par_t o_par,
    input wire logic o_err,
    input wire icp_pkg::icp_rsp_t i_rsp,
    input wire logic o_rsp_ready,
    input wire icp_pkg::icp_tx_t o_tx,
    input wire logic i_tx_ready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // a request is taken only while the formatter is idle
    sequence s_take;
        i_rsp.valid && o_rsp_ready;
    endsequence
    sequence s_bool;
        s_take ##0 i_rsp.kind == icp_pkg::RK_BOOL;
    endsequence
    a_cmd_after_term: assert property (o_cmd.valid |-> $past(i_rx.valid) &&
        ($past(i_rx.data) == icp_pkg::CH_LF || $past(i_rx.data) == icp_pkg::CH_SEMI || $past(i_rx.eoi)))
        else $error("command without terminating byte");
    a_par_echo: assert property (o_par.valid |-> $past(i_rx.valid) && o_par.data == $past(i_rx.data))
        else $error("parameter byte differs from input");
    a_blank_silent: assert property (i_rx.valid && i_rx.data <= icp_pkg::CH_WS_MAX |=> !o_par.valid)
        else $error("white space passed as parameter");
    a_comma_silent: assert property (i_rx.valid && i_rx.data == icp_pkg::CH_COMMA |=> !o_par.valid)
        else $error("comma passed as parameter");
    a_one_verdict: assert property (!(o_cmd.valid && o_err))
        else $error("command and error together");
    a_common_root: assert property (o_cmd.valid && o_cmd.common |-> o_cmd.node == 5'h00)
        else $error("common command with a tree node");
    a_tx_hold: assert property (o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx))
        else $error("response byte dropped before acceptance");
    a_eoi_lf: assert property (o_tx.valid && o_tx.eoi |-> o_tx.data == icp_pkg::CH_LF)
        else $error("eoi on a byte other than newline");
    a_bool_digit: assert property (s_bool |=> o_tx.valid && o_tx.data[7:1] == icp_pkg::CH_ZERO[7:1])
        else $error("boolean answer not 0 or 1");
    a_rsp_busy: assert property (s_take |=> !o_rsp_ready [*2])
        else $error("formatter idle right after a request");
    a_rsp_done: assert property (s_take |-> ##[1:600] (o_tx.valid && o_tx.eoi && i_tx_ready))
        else $error("response never completed");
endmodule
bind icp_parser icp_parser_asserts u_icp_parser_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx(i_rx),
    .o_cmd(o_cmd), .o_par(o_par), .o_err(o_err), .i_rsp(i_rsp), .o_rsp_ready(o_rsp_ready), .o_tx(o_tx),
    .i_tx_ready(i_tx_ready));
`default_nettype wire

// >>> icp_ctrl_model.sv
// icp_ctrl_model: remote controller sending lines and sinking responses
`timescale 1ns/100ps
`default_nettype none
module icp_ctrl_model (
    input wire logic i_clk,
    input wire icp_pkg::icp_tx_t i_tx,
    input wire logic i_slow,
    output icp_pkg::icp_rx_t o_rx,
    output logic o_tx_ready
);
    logic [7:0] got[$];
    logic [1:0] cnt_q = 2'h0;
    initial o_rx = '0;
    // slow mode accepts one beat in four so the hold rule gets exercised
    assign o_tx_ready = !i_slow || cnt_q == 2'h3;
    always @(posedge i_clk) begin
        cnt_q <= cnt_q + 2'h1;
        if (i_tx.valid && o_tx_ready) got.push_back(i_tx.data);
    end
    // ascii bytes back to back, eoi optionally on the last one
    task automatic send(input string s, input logic eoi);
        for (int i = 0; i < s.len(); i++) begin
            @(negedge i_clk);
            o_rx = '{1'b1, s[i], eoi && i == s.len() - 1};
        end
        @(negedge i_clk);
        o_rx = '{1'b0, ~o_rx.data, 1'b0};
    endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// tb_top: self-checking bench for the command line parser
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic slow = 1'b0;
    logic err, rsp_ready, tx_ready;
    icp_pkg::icp_rx_t rx;
    icp_pkg::icp_cmd_t cmd, last_q;
    icp_pkg::icp_par_t par;
    icp_pkg::icp_rsp_t rsp = '0;
    icp_pkg::icp_tx_t tx;
    logic [4:0] nodes[$];
    logic [11:0] pars[$];
    int n_err = 0;
    int bad_count = 0;
    int checks = 0;
    icp_parser u_icp_parser (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx(rx), .o_cmd(cmd), .o_par(par),
        .o_err(err), .i_rsp(rsp), .o_rsp_ready(rsp_ready), .o_tx(tx), .i_tx_ready(tx_ready));
    icp_ctrl_model u_icp_ctrl_model (.i_clk(i_clk), .i_tx(tx), .i_slow(slow), .o_rx(rx), .o_tx_ready(tx_ready));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    // outputs stand one cycle, so every pulse is logged
    always @(posedge i_clk) begin
        if (cmd.valid) last_q = cmd;
        if (cmd.valid) nodes.push_back(cmd.node);
        if (par.valid) pars.push_back({par.index, par.data});
        if (err) n_err++;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic line(input string s, input logic eoi, input int ncmd, input logic [4:0] node, input int nerr);
        nodes.delete();
        pars.delete();
        n_err = 0;
        u_icp_ctrl_model.send(s, eoi);
        repeat (3) @(negedge i_clk);
        check("cmds", 16'(nodes.size()), 16'(ncmd));
        check("errs", 16'(n_err), 16'(nerr));
        if (ncmd > 0) check("node", 16'(last_q.node), 16'(node));
    endtask
    task automatic t_ends;
        line("FREQ 5\n", 1'b0, 1, 5'h02, 0);
        line("FREQ 5\n", 1'b1, 1, 5'h02, 0);
        line("FREQ 5", 1'b1, 1, 5'h02, 0);
        check("sfx", 16'(last_q.sfx[0]), 16'h0001);
        check("par", 16'(pars[0]), 16'h0035);
        check("nparam", 16'(last_q.nparam), 16'h0001);
    endtask
    task automatic t_tree;
        line("SOURce:POWer:LEVel:IMMediate:OFFSet 1\n", 1'b0, 1, 5'h06, 0);
        line("pow:offs 1\n", 1'b0, 1, 5'h06, 0);
        line("sour2:FM:POL 1\n", 1'b0, 1, 5'h0c, 0);
        line("FM:EXT2:POL 1\n", 1'b0, 1, 5'h0d, 0);
        check("sfx", 16'(last_q.sfx[1]), 16'h0002);
    endtask
    task automatic t_bad;
        line("FREQU 5\n", 1'b0, 0, 5'h00, 1);
        line("ZZZ 1;:FREQ 2\n", 1'b0, 1, 5'h02, 1);
        line("FM:EXT 1;POL 2;:OUTP 1\n", 1'b0, 3, 5'h0e, 0);
        check("bare", 16'(nodes[1]), 16'h000c);
        line("POL 2\n", 1'b0, 0, 5'h00, 1);
    endtask
    task automatic t_param;
        line("*ESE 1, 22\n", 1'b0, 1, 5'h00, 0);
        check("common", 16'(last_q.common), 16'h0001);
        check("cname", 16'(last_q.cname), 16'h5345);
        check("nparam", 16'(last_q.nparam), 16'h0002);
        check("par2", 16'(pars[2]), 16'h0132);
        line("POW:ATT? max\n", 1'b0, 1, 5'h10, 0);
        check("special", 16'(last_q.special), 16'(icp_pkg::SP_MAX));
        line("OUTP:STAT?\n", 1'b0, 1, 5'h0f, 0);
        check("query", 16'(last_q.query), 16'h0001);
    endtask
    task automatic rsp_one(input icp_pkg::icp_rkind_t k, input logic [15:0] v, input logic [4:0] n, input string e);
        u_icp_ctrl_model.got.delete();
        @(negedge i_clk);
        rsp = '{1'b1, k, v, n};
        do @(posedge i_clk); while (!rsp_ready);
        @(negedge i_clk);
        rsp = '{1'b0, k, ~v, n};
        for (int i = 0; i < 600 && u_icp_ctrl_model.got.size() < e.len(); i++) @(negedge i_clk);
        for (int i = 0; i < e.len(); i++) check("rsp", 16'(u_icp_ctrl_model.got[i]), 16'(e[i]));
    endtask
    task automatic t_rsp;
        rsp_one(icp_pkg::RK_BOOL, 16'h0001, 5'h0f, "1\n");
        rsp_one(icp_pkg::RK_BOOL, 16'h0000, 5'h0f, "0\n");
        slow = 1'b1;
        rsp_one(icp_pkg::RK_NUM, 16'h003c, 5'h10, "60\n");
        rsp_one(icp_pkg::RK_NUM, 16'h0000, 5'h10, "0\n");
        rsp_one(icp_pkg::RK_TEXT, 16'h0000, 5'h0d, "POL\n");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (16) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_ends();
        t_tree();
        t_bad();
        t_param();
        t_rsp();
        end_sim();
    end
endmodule
`default_nettype wire
